// [tpi_pkg.sv]
// Package of constants and carrier types for the postscaled timer interrupt stage
`default_nettype none

package tpi_pkg;

    // ****************************************************************
    // Postscaler sizing and reset values
    // ****************************************************************
    localparam int unsigned PS_WIDTH    = 4;
    localparam logic [3:0]  COUNT_ZERO  = 4'h0;
    localparam logic [3:0]  COUNT_STEP  = 4'h1;
    localparam logic [3:0]  SELECT_ONE  = 4'h0;

    // ****************************************************************
    // Flag path into the instruction clock domain
    // ****************************************************************
    localparam int unsigned SYNC_STAGES = 2;

    // Period timer control as seen by this stage
    typedef struct packed {
        logic [3:0] postscale_select;
        logic       period_interrupt_enable;
    } tpi_ctrl_t;

endpackage

`default_nettype wire

// [tpi_sync_stage.sv]
// Fixed-depth flip-flop chain that carries the postscaled event toward the flag
`default_nettype none

module tpi_sync_stage #(
    parameter int unsigned STAGES = tpi_pkg::SYNC_STAGES
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_d,
    output var  logic o_q
);

    logic [STAGES-1:0] chain_ff;

    // Only the next stage reads each flop, so a late edge resolves before use
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[STAGES-2:0], i_d};
        end
    end

    assign o_q = chain_ff[STAGES-1];

endmodule

`default_nettype wire

// [tpi_postscaler.sv]
// Postscaler counter and interrupt flag stage of an 8-bit period timer
`default_nettype none

module tpi_postscaler #(
    parameter int unsigned PS_BITS = tpi_pkg::PS_WIDTH
) (
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    input  wire logic               i_period_match,
    input  wire tpi_pkg::tpi_ctrl_t i_control,
    input  wire logic               i_flag_clear,
    output var  logic               o_postscaled_event,
    output var  logic               o_timer_interrupt_flag,
    output var  logic               o_interrupt_request,
    output var  logic [PS_BITS-1:0] o_postscale_count
);

    // ****************************************************************
    // Postscaler counter
    // ****************************************************************
    logic [PS_BITS-1:0] count_ff;
    logic [PS_BITS-1:0] nxt_count;
    logic               postscaled_ff;
    logic               nxt_postscaled;
    logic               ratio_hit;

    // Greater-or-equal so a ratio lowered mid-count still fires on the next match
    assign ratio_hit = (count_ff >= PS_BITS'(i_control.postscale_select));

    always_comb begin
        nxt_postscaled = i_period_match && ratio_hit;
        nxt_count      = count_ff;
        if (i_period_match) begin
            if (ratio_hit) begin
                nxt_count = PS_BITS'(tpi_pkg::COUNT_ZERO);
            end else begin
                nxt_count = PS_BITS'(count_ff + PS_BITS'(tpi_pkg::COUNT_STEP));
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_ff <= PS_BITS'(tpi_pkg::COUNT_ZERO);
        end else begin
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            postscaled_ff <= 1'b0;
        end else begin
            postscaled_ff <= nxt_postscaled;
        end
    end

    // ****************************************************************
    // Flag path into the instruction clock domain
    // ****************************************************************
    logic sync_event;

    // Fed from the next-state term, so the flag lands two edges after the
    // postscaled event; the first stage duplicates postscaled_ff, a flop
    // spent to keep the event output and the flag path independent
    tpi_sync_stage #(
        .STAGES (tpi_pkg::SYNC_STAGES)
    ) u_flag_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_d     (nxt_postscaled),
        .o_q     (sync_event)
    );

    // ****************************************************************
    // Interrupt flag and gated request
    // ****************************************************************
    logic flag_ff;
    logic nxt_flag;
    logic irq_ff;
    logic nxt_irq;

    // A new event in the clearing cycle keeps the flag set
    assign nxt_flag = sync_event || (flag_ff && !i_flag_clear);
    // Enable gates only the request; the flag itself is never masked
    assign nxt_irq  = nxt_flag && i_control.period_interrupt_enable;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign o_postscaled_event     = postscaled_ff;
    assign o_timer_interrupt_flag = flag_ff;
    assign o_interrupt_request    = irq_ff;
    assign o_postscale_count      = count_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence seq_ratio_hit;
        i_period_match && (count_ff >= PS_BITS'(i_control.postscale_select));
    endsequence

    // One edge through the second synchroniser stage, one into the flag
    sequence seq_flag_path;
        postscaled_ff ##2 flag_ff;
    endsequence

    // A clear that meets no synchronised event
    sequence seq_clear_only;
        i_flag_clear && !sync_event;
    endsequence

    a_event_at_ratio: assert property (
        @(posedge i_clock) disable iff (i_rst)
        seq_ratio_hit |=> postscaled_ff
    ) else $error("postscaled event missing at selected ratio");

    a_event_needs_match: assert property (
        @(posedge i_clock) disable iff (i_rst)
        postscaled_ff |-> $past(i_period_match) && $past(ratio_hit)
    ) else $error("postscaled event without a ratio hit");

    a_ratio_one: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_period_match && i_control.postscale_select == tpi_pkg::SELECT_ONE)
            |=> postscaled_ff && count_ff == PS_BITS'(tpi_pkg::COUNT_ZERO)
    ) else $error("ratio 1:1 did not fire on every match");

    a_count_advance: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_period_match && !ratio_hit)
            |=> count_ff == PS_BITS'($past(count_ff) + PS_BITS'(tpi_pkg::COUNT_STEP))
    ) else $error("postscale count did not advance on match");

    a_count_hold: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !i_period_match |=> $stable(count_ff) && !postscaled_ff
    ) else $error("postscale count moved without a match");

    a_count_wrap: assert property (
        @(posedge i_clock) disable iff (i_rst)
        postscaled_ff |-> count_ff == PS_BITS'(tpi_pkg::COUNT_ZERO)
    ) else $error("postscale count not cleared after event");

    a_flag_lag: assert property (
        @(posedge i_clock) disable iff (i_rst)
        seq_ratio_hit |=> seq_flag_path
    ) else $error("flag not set within two cycles of event");

    a_flag_cause: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $rose(flag_ff) |-> $past(postscaled_ff, 2)
    ) else $error("flag rose without a postscaled event");

    a_set_wins: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (sync_event && i_flag_clear) |=> flag_ff
    ) else $error("flag clear overrode a new event");

    a_irq_gated: assert property (
        @(posedge i_clock) disable iff (i_rst)
        ##1 (irq_ff == (flag_ff && $past(i_control.period_interrupt_enable)))
    ) else $error("interrupt request not gated by enable");

    a_clear_drops: assert property (
        @(posedge i_clock) disable iff (i_rst)
        seq_clear_only |=> !flag_ff && !irq_ff
    ) else $error("flag clear did not drop the flag");

    // The second synchroniser stage of the flag path must add exactly one edge
    a_sync_follows: assert property (
        @(posedge i_clock) disable iff (i_rst)
        postscaled_ff |=> sync_event
    ) else $error("synchronised event did not follow the postscaled event");

    // Masking must hold the request low whatever the flag does
    a_mask_request: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !i_control.period_interrupt_enable |=> !irq_ff
    ) else $error("request raised while enable was clear");

    a_irq_needs_flag: assert property (
        @(posedge i_clock) disable iff (i_rst)
        irq_ff |-> flag_ff
    ) else $error("request raised without the flag");

    a_irq_follows: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (flag_ff && !i_flag_clear && i_control.period_interrupt_enable) |=> irq_ff
    ) else $error("request missing while flag set and enabled");

    // The enable must not hold back the flag itself
    a_flag_unmasked: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_period_match && ratio_hit && !i_control.period_interrupt_enable)
            |=> ##2 flag_ff
    ) else $error("flag held back while enable was clear");

    // Above 1:1 the cleared count cannot hit again on the very next match
    a_event_pulse: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (postscaled_ff && i_control.postscale_select != tpi_pkg::SELECT_ONE)
            |=> !postscaled_ff
    ) else $error("postscaled event repeated above ratio 1:1");

endmodule

`default_nettype wire

// [tpi_postscaler_tb.sv]
// Self-checking bench for the postscaler and interrupt flag stage
`default_nettype none

module timer_postscaled_interrupt_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic               i_clock = 1'b0;
    logic               i_rst   = 1'b1;
    logic               i_period_match = 1'b0;
    tpi_pkg::tpi_ctrl_t i_control      = '0;
    logic               i_flag_clear   = 1'b0;
    logic               o_postscaled_event;
    logic               o_timer_interrupt_flag;
    logic               o_interrupt_request;
    logic [3:0]         o_postscale_count;
    int                 miscompares = 0;
    int                 n_checks    = 0;
    int unsigned        seed        = 74140;
    int                 m_cnt;
    logic               m_ev, m_sync, m_flag, m_irq;

    always #20 i_clock = ~i_clock;

    tpi_postscaler DUT (
        .i_clock                (i_clock),
        .i_rst                  (i_rst),
        .i_period_match         (i_period_match),
        .i_control              (i_control),
        .i_flag_clear           (i_flag_clear),
        .o_postscaled_event     (o_postscaled_event),
        .o_timer_interrupt_flag (o_timer_interrupt_flag),
        .o_interrupt_request    (o_interrupt_request),
        .o_postscale_count      (o_postscale_count)
    );

    // ****************************************************************
    // Comparison and reporting
    // ****************************************************************
    task automatic chk_bit(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input logic [3:0] e, input logic [3:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic int unsigned xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // ****************************************************************
    // One clock: drive at falling edge, model at rising, compare after
    // ****************************************************************
    task automatic cyc(input logic m, input logic [3:0] s, input logic e, input logic c);
        logic hit;
        logic nflag;
        i_period_match = m;
        i_control      = '{postscale_select: s, period_interrupt_enable: e};
        i_flag_clear   = c;
        @(posedge i_clock);
        hit    = m && (m_cnt >= int'(s));
        // The flag lags the postscaled event by two edges: one through the second synchroniser stage, one into the flag
        nflag  = m_sync ? 1'b1 : (c ? 1'b0 : m_flag);
        m_irq  = nflag & e;
        m_flag = nflag;
        m_sync = m_ev;
        m_ev   = hit;
        m_cnt  = m ? (hit ? 0 : m_cnt + 1) : m_cnt;
        @(negedge i_clock);
        chk_bit("event", m_ev, o_postscaled_event);
        chk_bit("flag", m_flag, o_timer_interrupt_flag);
        chk_bit("request", m_irq, o_interrupt_request);
        chk_cnt("count", m_cnt[3:0], o_postscale_count);
    endtask

    task automatic do_reset(input int n);
        i_rst = 1'b1;
        m_cnt = 0;
        m_ev = 1'b0;
        m_sync = 1'b0;
        m_flag = 1'b0;
        m_irq = 1'b0;
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
        chk_bit("flag in reset", 1'b0, o_timer_interrupt_flag);
        chk_cnt("count in reset", 4'h0, o_postscale_count);
        chk_bit("event in reset", 1'b0, o_postscaled_event);
        chk_bit("request in reset", 1'b0, o_interrupt_request);
        i_rst = 1'b0;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int unsigned r;
        do_reset(12);
        // Every ratio, back-to-back matches, cleared at each start
        for (int s = 0; s < 16; s++) begin
            cyc(1'b0, 4'(s), 1'b1, 1'b1);
            repeat (2 * (s + 1) + 3) cyc(1'b1, 4'(s), 1'b1, 1'b0);
        end
        // Flag keeps setting while the request is masked
        repeat (6) cyc(1'b1, 4'h1, 1'b0, 1'b0);
        cyc(1'b0, 4'h1, 1'b1, 1'b0);
        // Reset in mid-count, then random traffic with select changes
        cyc(1'b1, 4'hF, 1'b1, 1'b0);
        do_reset(2);
        for (int k = 0; k < 600; k++) begin
            r = xorshift();
            cyc(r[0] | r[1], r[7:4], r[8], r[11:9] == 3'h0);
        end
        complete_run();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge i_clock);
        miscompares++;
        complete_run();
    end
endmodule

`default_nettype wire
